// *** fpr_defines.svh ***
// register offsets, field positions, reset values and counts of the fiber event and pattern block
// assumes a 32-bit bus, one aligned word per register, byte address = index * 4
// Notes on behaviour
// - one enable per event, bits 14..4 except 6; all clear on hard reset
// - bit 14 latches high when resolved fiber speed changes
// - bit 13 latches high when resolved fiber duplex changes
// - bit 12 latches high when a negotiation page arrives
// - bit 11 latches high when fiber negotiation completes
// - bit 10 latches high when fiber link toggles up or down
// - bit 9 latches high on a received symbol error
// - bit 8 latches high on false carrier detection
// - bit 7 latches high on elastic buffer overflow or underflow
// - bit 5 latches high when received remote fault changes
// - bit 4 latches high when energy detect changes either way
// - bit 7 inverts checker data, bit 6 inverts generator data
// - bit 5 set: error counting waits until checker first locks
// - writing 1 to bit 4 clears the counter, bit self-clears
// - bits 3:2 select pattern: 7, 23, 31 stage sequences or alternating
// - bit 1 enables checker, bit 0 generator; both clear on any reset
// - low word read snapshots the high word
// - counter words cleared only by the clear bit or hard reset, not reads or soft reset
// - remote fault field: none, partner link failure, offline, negotiation error
// - force bit drives the interrupt output active regardless of status
`ifndef FPR_DEFINES_SVH
`define FPR_DEFINES_SVH
`define FPR_IDX_EN 6'h12
`define FPR_IDX_ST 6'h13
`define FPR_IDX_CTL 6'h17
`define FPR_IDX_LO 6'h18
`define FPR_IDX_HI 6'h19
`define FPR_IDX_FRC 6'h1a
`define FPR_IDX_RF 6'h1b
`define FPR_A_EN {`FPR_IDX_EN, 2'b00}
`define FPR_A_ST {`FPR_IDX_ST, 2'b00}
`define FPR_A_CTL {`FPR_IDX_CTL, 2'b00}
`define FPR_A_LO {`FPR_IDX_LO, 2'b00}
`define FPR_A_HI {`FPR_IDX_HI, 2'b00}
`define FPR_A_FRC {`FPR_IDX_FRC, 2'b00}
`define FPR_A_RF {`FPR_IDX_RF, 2'b00}
`define FPR_EV_MASK 16'h7fb0
`define FPR_EN_SWCLR 16'h0020
`define FPR_CTL_SWCLR 16'h0013
`define FPR_CTL_RST 16'h0000
`define FPR_EN_RST 16'h0000
`define FPR_B_SPEED 14
`define FPR_B_DUPLEX 13
`define FPR_B_PAGE 12
`define FPR_B_AN 11
`define FPR_B_LINK 10
`define FPR_B_SYM 9
`define FPR_B_FCAR 8
`define FPR_B_FIFO 7
`define FPR_B_RF 5
`define FPR_B_ENERGY 4
`define FPR_C_CHK_INV 7
`define FPR_C_GEN_INV 6
`define FPR_C_LOCK 5
`define FPR_C_CLR 4
`define FPR_C_SEL_HI 3
`define FPR_C_SEL_LO 2
`define FPR_C_CHK_EN 1
`define FPR_C_GEN_EN 0
`define FPR_B_FORCE 15
`define FPR_RF_HI 7
`define FPR_RF_LO 6
`define FPR_LOCK_RUN 6'd32
`define FPR_SEED 31'h7fffffff
`endif

// *** fpr_pkg.sv ***
// types shared by the fiber event register block and its pattern unit
// assumes fpr_defines.svh carries all numeric constants
package fpr_pkg;
  typedef enum logic [1:0] {PAT_P7 = 2'b00, PAT_P23 = 2'b01, PAT_P31 = 2'b10,
                            PAT_ALT = 2'b11} fpr_pat_t;
  typedef enum logic [1:0] {RF_NONE = 2'b00, RF_LINK_FAIL = 2'b01, RF_OFFLINE = 2'b10,
                            RF_AN_ERR = 2'b11} fpr_rf_t;
  typedef enum logic [2:0] {CHK_OFF = 3'b001, CHK_HUNT = 3'b010,
                            CHK_LOCK = 3'b100} fpr_chk_st_t;
  typedef struct packed {
    logic [1:0] speed;
    logic duplex;
    logic page_rx;
    logic an_done;
    logic link_up;
    logic sym_err;
    logic false_carrier;
    logic fifo_err;
    fpr_rf_t remote_fault;
    logic energy;
  } fpr_fiber_t;
  typedef struct packed {
    logic chk_inv;
    logic gen_inv;
    fpr_pat_t sel;
    logic chk_en;
    logic gen_en;
  } fpr_pat_ctl_t;
endpackage

// *** fpr_prbs.sv ***
// pattern generator and self-synchronising checker, one bit per clock
// assumes the serial link bits are synchronous to clk_i
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_prbs (
  input wire logic clk_i,
  input wire logic rst_ni,
  input wire fpr_pkg::fpr_pat_ctl_t ctl_i,
  input wire logic rx_bit_i,
  output logic tx_bit_o,
  output logic err_o,
  output logic locked_o
);
  function automatic logic fb(input logic [30:0] s, input fpr_pkg::fpr_pat_t sel);
    case (sel)
      fpr_pkg::PAT_P7: fb = s[6] ^ s[5];
      fpr_pkg::PAT_P23: fb = s[22] ^ s[17];
      fpr_pkg::PAT_P31: fb = s[30] ^ s[27];
      default: fb = ~s[0];
    endcase
  endfunction

  logic [30:0] gen_q;
  logic [30:0] chk_q;
  logic [5:0] run_q;
  logic [5:0] run_d;
  fpr_pkg::fpr_pat_t sel_q;
  fpr_pkg::fpr_chk_st_t st_q;
  fpr_pkg::fpr_chk_st_t st_d;
  wire logic gen_bit = fb(gen_q, ctl_i.sel);
  wire logic rx_bit = rx_bit_i ^ ctl_i.chk_inv;
  wire logic miss = rx_bit != fb(chk_q, ctl_i.sel);
  wire logic resync = ctl_i.sel != sel_q;
  assign run_d = miss ? 6'd0 : run_q + 6'd1;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      fpr_pkg::CHK_OFF: if (ctl_i.chk_en) st_d = fpr_pkg::CHK_HUNT;
      fpr_pkg::CHK_HUNT: if (run_q == `FPR_LOCK_RUN) st_d = fpr_pkg::CHK_LOCK;
      fpr_pkg::CHK_LOCK: if (resync) st_d = fpr_pkg::CHK_HUNT;
      default: st_d = fpr_pkg::CHK_OFF;
    endcase
    if (!ctl_i.chk_en)
      st_d = fpr_pkg::CHK_OFF;
  end

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      gen_q <= `FPR_SEED;
      chk_q <= `FPR_SEED;
      run_q <= 6'd0;
      sel_q <= fpr_pkg::PAT_P7;
      st_q <= fpr_pkg::CHK_OFF;
      tx_bit_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      gen_q <= ctl_i.gen_en ? {gen_q[29:0], gen_bit} : `FPR_SEED;
      tx_bit_o <= ctl_i.gen_en & (gen_bit ^ ctl_i.gen_inv);
      chk_q <= {chk_q[29:0], rx_bit};
      sel_q <= ctl_i.sel;
      run_q <= (st_q == fpr_pkg::CHK_HUNT && !resync) ? run_d : 6'd0;
      st_q <= st_d;
      err_o <= (st_q != fpr_pkg::CHK_OFF) & ctl_i.chk_en & miss;
    end
  end
  assign locked_o = st_q == fpr_pkg::CHK_LOCK;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_ni);
  a_alt_toggle: assert property (
    (ctl_i.gen_en && ctl_i.sel == fpr_pkg::PAT_ALT && $stable(ctl_i.gen_inv))[*3]
    |-> tx_bit_o != $past(tx_bit_o))
    else $error("alternating pattern did not toggle");
  a_gen_idle: assert property (!ctl_i.gen_en |=> !tx_bit_o)
    else $error("generator output active while disabled");
  a_lock_after_run: assert property (
    $rose(locked_o) |-> $past(run_q) == `FPR_LOCK_RUN)
    else $error("checker locked without a full good run");
endmodule

// *** fpr_regs.sv ***
// fiber event enable and status registers with pattern test control on an APB slave
// assumes event inputs are synchronous to CLK_I and SW_RESET_I is a one-cycle pulse
`timescale 1ns/1ps
`include "fpr_defines.svh"
module fpr_regs (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SW_RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire fpr_pkg::fpr_fiber_t FIBER_I,
  input wire logic RX_BIT_I,
  output logic TX_BIT_O,
  output logic PATTERN_LOCKED_O,
  output logic INTERRUPT_OUT_LOW_N_O
);
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // bus decode
  wire logic setup = PSEL_I & ~PENABLE_I;
  wire logic access = PSEL_I & PENABLE_I;
  wire logic hit_en = PADDR_I == `FPR_A_EN;
  wire logic hit_st = PADDR_I == `FPR_A_ST;
  wire logic hit_ctl = PADDR_I == `FPR_A_CTL;
  wire logic hit_lo = PADDR_I == `FPR_A_LO;
  wire logic hit_hi = PADDR_I == `FPR_A_HI;
  wire logic hit_frc = PADDR_I == `FPR_A_FRC;
  wire logic hit_rf = PADDR_I == `FPR_A_RF;
  wire logic mapped = hit_en | hit_st | hit_ctl | hit_lo | hit_hi | hit_frc | hit_rf;
  wire logic wr = access & PWRITE_I & mapped;
  wire logic rd_setup = setup & ~PWRITE_I;
  wire logic rd_st_done = access & ~PWRITE_I & hit_st;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~mapped;

  // change detectors need one primed cycle so reset values do not look like events
  logic primed_q;
  logic [1:0] speed_q;
  logic duplex_q;
  logic link_q;
  fpr_pkg::fpr_rf_t rf_q;
  logic energy_q;
  logic [15:0] ev;
  assign ev[15] = 1'b0;
  assign ev[`FPR_B_SPEED] = primed_q & (FIBER_I.speed != speed_q);
  assign ev[`FPR_B_DUPLEX] = primed_q & (FIBER_I.duplex != duplex_q);
  assign ev[`FPR_B_PAGE] = FIBER_I.page_rx;
  assign ev[`FPR_B_AN] = FIBER_I.an_done;
  assign ev[`FPR_B_LINK] = primed_q & (FIBER_I.link_up != link_q);
  assign ev[`FPR_B_SYM] = FIBER_I.sym_err;
  assign ev[`FPR_B_FCAR] = FIBER_I.false_carrier;
  assign ev[`FPR_B_FIFO] = FIBER_I.fifo_err;
  assign ev[6] = 1'b0;
  assign ev[`FPR_B_RF] = primed_q & (FIBER_I.remote_fault != rf_q);
  assign ev[`FPR_B_ENERGY] = primed_q & (FIBER_I.energy != energy_q);
  assign ev[3:0] = 4'h0;

  always_ff @(posedge CLK_I or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      primed_q <= 1'b0;
      speed_q <= 2'h0;
      duplex_q <= 1'b0;
      link_q <= 1'b0;
      rf_q <= fpr_pkg::RF_NONE;
      energy_q <= 1'b0;
    end
    else
    begin
      primed_q <= 1'b1;
      speed_q <= FIBER_I.speed;
      duplex_q <= FIBER_I.duplex;
      link_q <= FIBER_I.link_up;
      rf_q <= FIBER_I.remote_fault;
      energy_q <= FIBER_I.energy;
    end
  end

  // status: only the bits shown to the read are cleared, so a late event survives
  logic [15:0] st_q;
  logic [15:0] st_d;
  logic [15:0] st_clr;
  assign st_clr = {16{rd_st_done}} & PRDATA_O[15:0];
  assign st_d = SW_RESET_I ? 16'h0000 : (((st_q & ~st_clr) | ev) & `FPR_EV_MASK);

  // enables
  logic [15:0] en_q;
  logic [15:0] en_d;
  assign en_d = (wr & hit_en) ? (PWDATA_I[15:0] & `FPR_EV_MASK) :
                SW_RESET_I ? (en_q & ~`FPR_EN_SWCLR) : en_q;

  // pattern control; the clear bit lives for one cycle only
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  wire logic cnt_clr = ctl_q[`FPR_C_CLR];
  assign ctl_d = (wr & hit_ctl) ? PWDATA_I[15:0] :
                 SW_RESET_I ? (ctl_q & ~`FPR_CTL_SWCLR) :
                 {ctl_q[15:5], 1'b0, ctl_q[3:0]};

  logic force_q;

  always_ff @(posedge CLK_I or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q <= 16'h0000;
      en_q <= `FPR_EN_RST;
      ctl_q <= `FPR_CTL_RST;
      force_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      en_q <= en_d;
      ctl_q <= ctl_d;
      if (wr & hit_frc)
        force_q <= PWDATA_I[`FPR_B_FORCE];
    end
  end

  // pattern unit
  fpr_pkg::fpr_pat_ctl_t pat_ctl;
  logic chk_err;
  logic chk_locked;
  assign pat_ctl.chk_inv = ctl_q[`FPR_C_CHK_INV];
  assign pat_ctl.gen_inv = ctl_q[`FPR_C_GEN_INV];
  assign pat_ctl.sel = fpr_pkg::fpr_pat_t'(ctl_q[`FPR_C_SEL_HI:`FPR_C_SEL_LO]);
  assign pat_ctl.chk_en = ctl_q[`FPR_C_CHK_EN];
  assign pat_ctl.gen_en = ctl_q[`FPR_C_GEN_EN];

  fpr_prbs u_prbs (
    .clk_i(CLK_I),
    .rst_ni(rst_n_q),
    .ctl_i(pat_ctl),
    .rx_bit_i(RX_BIT_I),
    .tx_bit_o(TX_BIT_O),
    .err_o(chk_err),
    .locked_o(chk_locked)
  );
  assign PATTERN_LOCKED_O = chk_locked;

  // error counter saturates rather than wrapping to a misleading small value
  logic [31:0] cnt_q;
  logic [15:0] hi_q;
  logic armed_q;
  wire logic count_ok = ~ctl_q[`FPR_C_LOCK] | armed_q | chk_locked;
  wire logic cnt_inc = chk_err & count_ok & ~(&cnt_q);

  // soft reset deliberately does not touch the counter or its snapshot
  always_ff @(posedge CLK_I or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cnt_q <= 32'h0000_0000;
      hi_q <= 16'h0000;
      armed_q <= 1'b0;
    end
    else
    begin
      armed_q <= pat_ctl.chk_en & ~cnt_clr & (armed_q | chk_locked);
      if (cnt_clr)
        cnt_q <= 32'h0000_0000;
      else if (cnt_inc)
        cnt_q <= cnt_q + 32'h0000_0001;
      if (cnt_clr)
        hi_q <= 16'h0000;
      else if (rd_setup & hit_lo)
        hi_q <= cnt_q[31:16];
    end
  end

  // read data is taken in the setup cycle so the access cycle can finish at once
  logic [31:0] rd_mux;
  assign rd_mux = hit_en ? {16'h0000, en_q} :
                  hit_st ? {16'h0000, st_q} :
                  hit_ctl ? {16'h0000, ctl_q} :
                  hit_lo ? {16'h0000, cnt_q[15:0]} :
                  hit_hi ? {16'h0000, hi_q} :
                  hit_frc ? {16'h0000, force_q, 15'h0000} :
                  hit_rf ? {24'h00_0000, FIBER_I.remote_fault, 6'h00} : 32'h0000_0000;

  logic int_n_q;
  always_ff @(posedge CLK_I or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      PRDATA_O <= 32'h0000_0000;
      int_n_q <= 1'b1;
    end
    else
    begin
      if (rd_setup)
        PRDATA_O <= rd_mux;
      int_n_q <= ~(force_q | (|(st_q & en_q)));
    end
  end
  assign INTERRUPT_OUT_LOW_N_O = int_n_q;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!rst_n_q);

  sequence s_clr_write;
    wr && hit_ctl && PWDATA_I[`FPR_C_CLR];
  endsequence
  sequence s_clr_pulse;
    ctl_q[`FPR_C_CLR] ##1 (cnt_q == 32'h0000_0000 && hi_q == 16'h0000);
  endsequence
  sequence s_speed_move;
    primed_q && FIBER_I.speed != speed_q && !SW_RESET_I;
  endsequence

  a_speed_latch: assert property (
    s_speed_move |=> st_q[`FPR_B_SPEED] && en_q == $past(en_d))
    else $error("speed change not latched");
  a_event_latch: assert property (
    !SW_RESET_I |=> (st_q & $past(ev)) == $past(ev))
    else $error("status event lost");
  a_status_hold: assert property (
    !SW_RESET_I && !rd_st_done |=> (st_q & $past(st_q)) == $past(st_q))
    else $error("status bit dropped without a read");
  a_read_clears: assert property (
    rd_st_done && ev == 16'h0000 && !SW_RESET_I |=> (st_q & $past(PRDATA_O[15:0])) == 16'h0000)
    else $error("status read did not clear reported bits");
  a_enable_write: assert property (
    wr && hit_en |=> en_q == ($past(PWDATA_I[15:0]) & `FPR_EV_MASK))
    else $error("enable write not stored under mask");
  a_int_assert: assert property (
    (|(st_q & en_q)) |=> !INTERRUPT_OUT_LOW_N_O)
    else $error("interrupt missing for enabled status");
  a_int_force: assert property (
    force_q [*2] |-> !INTERRUPT_OUT_LOW_N_O)
    else $error("forced interrupt not asserted");
  a_int_idle: assert property (
    !force_q && (st_q & en_q) == 16'h0000 |=> INTERRUPT_OUT_LOW_N_O)
    else $error("interrupt active with nothing pending");
  a_clear_count: assert property (
    s_clr_write |=> s_clr_pulse ##0 !ctl_q[`FPR_C_CLR] || $past(wr && hit_ctl))
    else $error("counter clear did not act or self-clear");
  a_lock_wait: assert property (
    ctl_q[`FPR_C_LOCK] && !armed_q && !chk_locked && !cnt_clr |=> $stable(cnt_q))
    else $error("counter ran before pattern lock");
  a_soft_reset: assert property (
    SW_RESET_I && !cnt_clr && !(wr && hit_ctl)
    |=> ctl_q[`FPR_C_CHK_EN:`FPR_C_GEN_EN] == 2'b00 && cnt_q >= $past(cnt_q))
    else $error("soft reset handled wrongly");
  a_snapshot: assert property (
    rd_setup && hit_lo && !cnt_clr |=> hi_q == $past(cnt_q[31:16]) && PRDATA_O[15:0] ==
    $past(cnt_q[15:0]))
    else $error("high word snapshot mismatch");
  a_hi_frozen: assert property (
    !(rd_setup && hit_lo) && !cnt_clr |=> $stable(hi_q))
    else $error("high word moved without a low read");
  a_fault_view: assert property (
    rd_setup && hit_rf |=> PRDATA_O[`FPR_RF_HI:`FPR_RF_LO] == $past(FIBER_I.remote_fault))
    else $error("remote fault field mismatch");
  a_unmapped: assert property (
    access && !mapped |-> PSLVERR_O && PREADY_O)
    else $error("unmapped access not refused");
endmodule

// *** testbench.sv ***
// self-checking bench for the fiber event registers and pattern test unit over APB
// assumes fpr_pkg and fpr_defines.svh are compiled first; generator looped back to checker
`timescale 1ns/1ps
`include "fpr_defines.svh"
module testbench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic sw_reset = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fpr_pkg::fpr_fiber_t fiber = '0;
  logic rx_bit = 1'h0;
  logic tx_bit;
  logic locked;
  logic int_n;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;

  fpr_regs dut (
    .CLK_I(clk),
    .RST_N_I(rst_n),
    .SW_RESET_I(sw_reset),
    .PSEL_I(psel),
    .PENABLE_I(penable),
    .PWRITE_I(pwrite),
    .PADDR_I(paddr),
    .PWDATA_I(pwdata),
    .PRDATA_O(prdata),
    .PREADY_O(pready),
    .PSLVERR_O(pslverr),
    .FIBER_I(fiber),
    .RX_BIT_I(rx_bit),
    .TX_BIT_O(tx_bit),
    .PATTERN_LOCKED_O(locked),
    .INTERRUPT_OUT_LOW_N_O(int_n)
  );

  always #5 clk = ~clk;
  // loopback: the checker sees the generator one clock late
  always @(posedge clk) rx_bit <= tx_bit;

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // request held until pready is sampled high; data and error taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50)
      chk_bit(pready, 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'h1, a, {16'h0, d});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] d);
    apb(1'h0, a, 32'h0);
    chk_word(rd, {16'h0, d});
    chk_bit(er, 1'h0);
  endtask

  task automatic wait_lock();
    int n;
    n = 0;
    // a lock left from the previous setting takes one clock to drop
    cycles(2);
    while (locked !== 1'h1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // one event source per index; pulses last one clock, levels toggle
  task automatic ev(input int i);
    @(posedge clk);
    case (i)
      0: fiber.speed <= fiber.speed ^ 2'h1;
      1: fiber.duplex <= ~fiber.duplex;
      2: fiber.page_rx <= 1'h1;
      3: fiber.an_done <= 1'h1;
      4: fiber.link_up <= ~fiber.link_up;
      5: fiber.sym_err <= 1'h1;
      6: fiber.false_carrier <= 1'h1;
      7: fiber.fifo_err <= 1'h1;
      default: fiber.energy <= ~fiber.energy;
    endcase
    @(posedge clk);
    fiber.page_rx <= 1'h0;
    fiber.an_done <= 1'h0;
    fiber.sym_err <= 1'h0;
    fiber.false_carrier <= 1'h0;
    fiber.fifo_err <= 1'h0;
  endtask

  task automatic t_reset_enable();
    rd_chk(`FPR_A_EN, 16'h0000);
    rd_chk(`FPR_A_ST, 16'h0000);
    rd_chk(`FPR_A_CTL, 16'h0000);
    rd_chk(`FPR_A_LO, 16'h0000);
    rd_chk(`FPR_A_HI, 16'h0000);
    chk_bit(int_n, 1'h1);
    wr(`FPR_A_EN, 16'hffff);
    rd_chk(`FPR_A_EN, 16'h7fb0);
    apb(1'h0, 8'h40, 32'h0);
    chk_word(rd, 32'h0);
    chk_bit(er, 1'h1);
  endtask

  task automatic t_events();
    int bits[9] = '{14, 13, 12, 11, 10, 9, 8, 7, 4};
    for (int i = 0; i < 9; i++)
    begin
      ev(i);
      cycles(2);
      chk_bit(int_n, 1'h0);
      rd_chk(`FPR_A_ST, 16'h1 << bits[i]);
      rd_chk(`FPR_A_ST, 16'h0000);
      cycles(2);
      chk_bit(int_n, 1'h1);
    end
    wr(`FPR_A_EN, 16'h0000);
    ev(0);
    cycles(2);
    chk_bit(int_n, 1'h1);
    rd_chk(`FPR_A_ST, 16'h4000);
  endtask

  task automatic t_remote_fault();
    logic [1:0] c;
    for (int k = 1; k < 5; k++)
    begin
      c = 2'(k);
      @(posedge clk);
      fiber.remote_fault <= fpr_pkg::fpr_rf_t'(c);
      cycles(2);
      rd_chk(`FPR_A_RF, {8'h00, c, 6'h00});
      rd_chk(`FPR_A_ST, 16'h0020);
    end
    wr(`FPR_A_FRC, 16'h8000);
    cycles(2);
    chk_bit(int_n, 1'h0);
    wr(`FPR_A_FRC, 16'h0000);
    cycles(2);
    chk_bit(int_n, 1'h1);
  endtask

  // standard recurrences of the three sequences: feedback from stages 7/6, 23/18, 31/28
  task automatic chk_seq(input int s);
    logic [63:0] h;
    int t1;
    int t2;
    t1 = (s == 0) ? 7 : (s == 1) ? 23 : 31;
    t2 = (s == 0) ? 6 : (s == 1) ? 18 : 28;
    h = 64'h0;
    repeat (64)
    begin
      @(posedge clk);
      h = {h[62:0], tx_bit};
    end
    repeat (8)
    begin
      @(posedge clk);
      chk_bit(tx_bit, h[t1 - 1] ^ h[t2 - 1]);
      h = {h[62:0], tx_bit};
    end
  endtask

  task automatic t_patterns();
    logic [15:0] c;
    logic p;
    for (int s = 0; s < 4; s++)
    begin
      c = 16'h0003 | 16'(s << 2);
      wr(`FPR_A_CTL, c);
      wait_lock();
      chk_bit(locked, 1'h1);
      if (s < 3)
        chk_seq(s);
      wr(`FPR_A_CTL, c | 16'h0010);
      rd_chk(`FPR_A_CTL, c);
      cycles(20);
      rd_chk(`FPR_A_LO, 16'h0000);
      rd_chk(`FPR_A_HI, 16'h0000);
    end
    p = tx_bit;
    repeat (4)
    begin
      @(posedge clk);
      chk_bit(tx_bit, ~p);
      p = tx_bit;
    end
  endtask

  task automatic t_counter();
    wr(`FPR_A_CTL, 16'h0000);
    wr(`FPR_A_CTL, 16'h0063);
    cycles(100);
    rd_chk(`FPR_A_LO, 16'h0000);
    // inverted generator against a normal checker misses every bit
    wr(`FPR_A_CTL, 16'h0043);
    cycles(70000);
    apb(1'h0, `FPR_A_LO, 32'h0);
    rd_chk(`FPR_A_HI, 16'h0001);
    wr(`FPR_A_CTL, 16'h00c3);
    wait_lock();
    chk_bit(locked, 1'h1);
    wr(`FPR_A_EN, 16'h7fb0);
    @(posedge clk);
    sw_reset <= 1'h1;
    @(posedge clk);
    sw_reset <= 1'h0;
    cycles(2);
    rd_chk(`FPR_A_EN, 16'h7f90);
    rd_chk(`FPR_A_CTL, 16'h00c0);
    apb(1'h0, `FPR_A_LO, 32'h0);
    chk_bit(rd != 32'h0, 1'h1);
    rd_chk(`FPR_A_HI, 16'h0001);
    wr(`FPR_A_CTL, 16'h0010);
    cycles(2);
    rd_chk(`FPR_A_LO, 16'h0000);
    rd_chk(`FPR_A_HI, 16'h0000);
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_reset_enable();
    t_events();
    t_remote_fault();
    t_patterns();
    t_counter();
    stop_test();
  end

  // run needs about 72000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    $display("[ERR] %0t watchdog expired", $time);
    fail_count++;
    stop_test();
  end
endmodule
